// >>> core/efcs_op_timer.sv
`timescale 1ns/1ps
module efcs_op_timer (
  input wire logic clock, // 40 MHz
  input wire logic reset, // sync, high
  input wire logic start, // operation launch pulse
  input wire efcs_pkg::efcs_op_e kind, // operation kind
  input wire logic wide, // 128-byte program
  input wire logic abort, // halt on fault
  output logic busy, // operation running
  output logic done // one-cycle normal end
);
  typedef struct packed {
    logic [11:0] cnt;
    logic busy;
    logic done;
  } efcs_tmr_s;

  efcs_tmr_s s, n;

  // duration of each operation kind
  function automatic logic [11:0] opLen(efcs_pkg::efcs_op_e k, logic w);
    case (k)
      efcs_pkg::OP_PROG: opLen = w ? efcs_pkg::CYC_PROG128 : efcs_pkg::CYC_PROG8;
      efcs_pkg::OP_ERASE: opLen = efcs_pkg::CYC_ERASE;
      default: opLen = efcs_pkg::CYC_BLANK;
    endcase
  endfunction

  // countdown, abort stops without done
  always_comb begin
    n = s;
    n.done = 1'b0;
    if (start && !s.busy) begin
      n.cnt = opLen(kind, wide);
      n.busy = 1'b1;
    end else if (s.busy && abort) begin
      n.busy = 1'b0;
    end else if (s.busy) begin
      n.cnt = s.cnt - 12'h001;
      if (s.cnt == 12'h001) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
    if (reset) n = '0;
  end

  always_ff @(posedge clock) begin
    s <= n;
  end

  assign busy = s.busy;
  assign done = s.done;
endmodule

// >>> core/efcs_pkg.sv
package efcs_pkg;
  // clock rate and operation times
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned T_PROG8_NS = 2000;
  localparam int unsigned T_PROG128_NS = 20000;
  localparam int unsigned T_ERASE_NS = 100000;
  localparam int unsigned T_BLANK_NS = 1000;
  localparam logic [11:0] CYC_PROG8 = 12'((T_PROG8_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] CYC_PROG128 = 12'((T_PROG128_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] CYC_ERASE = 12'((T_ERASE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] CYC_BLANK = 12'((T_BLANK_NS * CLK_MHZ + 999) / 1000);
  // register offsets, bit 17 low selects the register space
  localparam logic [17:0] A_PSTAT = 18'h00000;
  localparam logic [17:0] A_SSTAT = 18'h00004;
  localparam logic [17:0] A_ASTAT = 18'h00008;
  localparam logic [17:0] A_AEIE = 18'h0000c;
  localparam logic [17:0] A_ENTRY = 18'h00010;
  localparam logic [17:0] A_WEN = 18'h00014;
  localparam logic [17:0] A_REN = 18'h00018;
  localparam logic [17:0] A_RMODE = 18'h0001c;
  localparam logic [17:0] A_BCCTL = 18'h00020;
  localparam logic [17:0] A_BCRES = 18'h00024;
  localparam int EEP_BIT = 17;
  // field positions
  localparam int P_READY = 7;
  localparam int P_ENTD = 7;
  localparam int P_RDMD = 4;
  localparam int P_CHECK_SIZE_BIT = 15;
  localparam logic [4:0] ASTAT_LOCK_ONLY = 5'h10;
  // command bytes and word counts
  localparam logic [7:0] CMD_PROG = 8'he8;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLANK = 8'h71;
  localparam logic [7:0] CMD_CLEAR = 8'h50;
  localparam logic [7:0] CMD_NORMAL = 8'hff;
  localparam logic [7:0] CMD_GO = 8'hd0;
  localparam logic [7:0] N_SMALL = 8'h04;
  localparam logic [7:0] N_LARGE = 8'h40;

  typedef enum logic [2:0] {S_IDLE, S_COUNT, S_DATA, S_PCONF, S_ECONF, S_BCONF} efcs_seq_e;
  typedef enum logic [1:0] {OP_PROG, OP_ERASE, OP_BLANK} efcs_op_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic fetch;
    logic word;
    logic [17:0] addr;
    logic [15:0] wdata;
  } efcs_bus_s;

  typedef struct packed {
    logic we;
    logic start;
    efcs_op_e kind;
    logic [16:0] addr;
    logic [15:0] wdata;
  } efcs_arr_s;
endpackage

// >>> core/efcs_sequencer.sv
`timescale 1ns/1ps
module efcs_sequencer (
  input wire logic clock, // 40 MHz
  input wire logic reset, // sync, high
  input wire efcs_pkg::efcs_bus_s bus, // register and eeprom access
  input wire logic romDisabled, // mode pins disable on-chip rom
  input wire logic [15:0] arrRdata, // array read data
  input wire logic arrBlank, // area erased at blank end
  input wire logic arrFail, // program/erase verify fail
  input wire logic arrFault, // internal fault
  input wire logic eccDetect, // read-detect error
  input wire logic eccCorrect, // read-correct error
  output logic [15:0] rdata, // read data, cycle after strobe
  output efcs_pkg::efcs_arr_s arr, // array write and launch
  output logic irq // error interrupt pulse
);
  typedef struct packed {
    efcs_pkg::efcs_seq_e seq;
    logic ready;
    logic ilgl, ers, prg, flt, rdt, rcr;
    logic acc, ife, rpe, wpe;
    logic lockIe;
    logic [3:0] ie;
    logic entD;
    logic [6:0] entRom;
    logic [15:0] wen;
    logic [15:0] ren;
    logic rdMode;
    logic check_size_bit;
    logic [9:0] bcOff;
    logic bcRes;
    logic statusRd;
    logic wide;
    logic [6:0] nWords;
    logic [6:0] cnt;
    logic [16:0] base;
    logic [4:0] prevSt;
    logic [15:0] rdata;
    logic irq;
    efcs_pkg::efcs_arr_s arr;
  } efcs_state_s;

  efcs_state_s s, n;
  logic opBusy, opDone, opAbort;
  logic isEep, cmdOk, lock;
  logic [3:0] blk;
  logic [7:0] cmd;

  function automatic logic errAny(efcs_state_s x);
    errAny = x.ilgl | x.ers | x.prg | x.flt | x.rdt | x.rcr;
  endfunction

  function automatic logic [15:0] pstat(efcs_state_s x);
    pstat = {8'h00, x.ready, x.ilgl, x.ers, x.prg, 4'h0};
  endfunction

  function automatic logic [4:0] astat(efcs_state_s x);
    astat = {errAny(x), x.acc, x.ife, x.rpe, x.wpe};
  endfunction

  efcs_op_timer tmr (
    .clock(clock),
    .reset(reset),
    .start(s.arr.start),
    .kind(s.arr.kind),
    .wide(s.wide),
    .abort(opAbort),
    .busy(opBusy),
    .done(opDone)
  );

  // access decode
  assign isEep = bus.addr[efcs_pkg::EEP_BIT];
  assign blk = bus.addr[16:13];
  assign cmd = bus.wdata[7:0];
  assign lock = errAny(s);
  assign cmdOk = isEep && bus.wr && !romDisabled && !bus.fetch && s.entRom == 7'h00 && s.entD;
  assign opAbort = opBusy && (arrFault || eccDetect || eccCorrect);

  // next state
  always_comb begin
    n = s;
    n.arr.we = 1'b0;
    n.arr.start = 1'b0;
    n.rdata = 16'h0000;
    // interrupt on rising enabled status
    n.prevSt = astat(s);
    n.irq = |(astat(s) & ~s.prevSt & {s.lockIe, s.ie});
    // operation end
    if (opDone) begin
      n.ready = 1'b1;
      n.flt = 1'b0;
      n.rdt = 1'b0;
      n.rcr = 1'b0;
      if (s.arr.kind == efcs_pkg::OP_BLANK) n.bcRes = !arrBlank;
    end
    // register writes
    if (bus.wr && !isEep) begin
      case (bus.addr)
        efcs_pkg::A_ASTAT: begin
          n.acc = s.acc & bus.wdata[3];
          n.ife = s.ife & bus.wdata[2];
          n.rpe = s.rpe & bus.wdata[1];
          n.wpe = s.wpe & bus.wdata[0];
        end
        efcs_pkg::A_AEIE: begin
          n.lockIe = bus.wdata[4];
          n.ie = bus.wdata[3:0];
        end
        efcs_pkg::A_ENTRY: begin
          n.entD = bus.wdata[efcs_pkg::P_ENTD];
          n.entRom = bus.wdata[6:0];
        end
        efcs_pkg::A_WEN: n.wen = bus.wdata;
        efcs_pkg::A_REN: n.ren = bus.wdata;
        efcs_pkg::A_RMODE: n.rdMode = bus.wdata[efcs_pkg::P_RDMD];
        efcs_pkg::A_BCCTL: begin
          n.check_size_bit = bus.wdata[efcs_pkg::P_CHECK_SIZE_BIT];
          n.bcOff = bus.wdata[12:3];
        end
        default: ;
      endcase
    end
    // register reads
    if (bus.rd && !isEep) begin
      case (bus.addr)
        efcs_pkg::A_PSTAT: n.rdata = pstat(s);
        efcs_pkg::A_SSTAT: n.rdata = {11'h000, s.flt, 2'b00, s.rdt, s.rcr};
        efcs_pkg::A_ASTAT: n.rdata = {11'h000, astat(s)};
        efcs_pkg::A_AEIE: n.rdata = {11'h000, s.lockIe, s.ie};
        efcs_pkg::A_ENTRY: n.rdata = {8'h00, s.entD, s.entRom};
        efcs_pkg::A_WEN: n.rdata = s.wen;
        efcs_pkg::A_REN: n.rdata = s.ren;
        efcs_pkg::A_RMODE: n.rdata = {11'h000, s.rdMode, 4'h0};
        efcs_pkg::A_BCCTL: n.rdata = {s.check_size_bit, 2'b00, s.bcOff, 3'b000};
        efcs_pkg::A_BCRES: n.rdata = {15'h0000, s.bcRes};
        default: n.rdata = 16'h0000;
      endcase
    end
    // eeprom space accesses, ignored while rom is disabled
    if (isEep && (bus.rd || bus.wr) && !romDisabled) begin
      if (bus.rd && bus.fetch) begin
        n.ilgl = 1'b1;
        n.ife = 1'b1;
      end else if (s.entRom != 7'h00 || (bus.wr && !s.entD)) begin
        n.ilgl = 1'b1;
        n.acc = 1'b1;
        n.seq = efcs_pkg::S_IDLE;
      end else if (bus.rd && s.entD) begin
        if (s.statusRd) n.rdata = pstat(s);
        else begin
          n.ilgl = 1'b1;
          n.acc = 1'b1;
        end
      end else if (bus.rd) begin
        if (s.ren[blk]) n.rdata = arrRdata;
        else begin
          n.ilgl = 1'b1;
          n.rpe = 1'b1;
        end
      end else if (lock) begin
        // only a clear at lock-only status unlocks
        if (cmd == efcs_pkg::CMD_CLEAR && astat(s) == efcs_pkg::ASTAT_LOCK_ONLY
            && !opBusy) begin
          n.ilgl = 1'b0;
          n.ers = 1'b0;
          n.prg = 1'b0;
          n.flt = 1'b0;
          n.rdt = 1'b0;
          n.rcr = 1'b0;
        end else n.ilgl = 1'b1;
        n.seq = efcs_pkg::S_IDLE;
      end else if (!s.ready || opBusy) begin
        n.ilgl = 1'b1;
        n.seq = efcs_pkg::S_IDLE;
      end else begin
        case (s.seq)
          efcs_pkg::S_IDLE: begin
            n.statusRd = 1'b1;
            case (cmd)
              efcs_pkg::CMD_PROG: n.seq = efcs_pkg::S_COUNT;
              efcs_pkg::CMD_ERASE: n.seq = efcs_pkg::S_ECONF;
              efcs_pkg::CMD_BLANK: begin
                // without read mode set this leaves status read mode, like the normal command
                if (s.rdMode) n.seq = efcs_pkg::S_BCONF;
                else n.statusRd = 1'b0;
              end
              efcs_pkg::CMD_CLEAR: ;
              efcs_pkg::CMD_NORMAL: n.statusRd = 1'b0;
              default: n.ilgl = 1'b1;
            endcase
          end
          efcs_pkg::S_COUNT: begin
            if (cmd == efcs_pkg::N_SMALL || cmd == efcs_pkg::N_LARGE) begin
              n.nWords = cmd[6:0];
              n.wide = cmd == efcs_pkg::N_LARGE;
              n.cnt = 7'h00;
              n.seq = efcs_pkg::S_DATA;
            end else begin
              n.ilgl = 1'b1;
              n.seq = efcs_pkg::S_IDLE;
            end
          end
          efcs_pkg::S_DATA: begin
            if (!bus.word || (s.cnt == 7'h00 && (s.wide ? bus.addr[6:0] != 7'h00
                : bus.addr[2:0] != 3'h0))) begin
              n.ilgl = 1'b1;
              n.seq = efcs_pkg::S_IDLE;
            end else begin
              if (s.cnt == 7'h00) n.base = bus.addr[16:0];
              n.arr.we = 1'b1;
              n.arr.addr = s.cnt == 7'h00 ? bus.addr[16:0] : 17'(s.base + {s.cnt, 1'b0});
              n.arr.wdata = bus.wdata;
              n.cnt = 7'(s.cnt + 7'h01);
              if (7'(s.cnt + 7'h01) == s.nWords) n.seq = efcs_pkg::S_PCONF;
            end
          end
          efcs_pkg::S_PCONF: begin
            n.seq = efcs_pkg::S_IDLE;
            if (cmd != efcs_pkg::CMD_GO) n.ilgl = 1'b1;
            else if (!s.wen[s.base[16:13]]) begin
              n.ilgl = 1'b1;
              n.wpe = 1'b1;
            end else begin
              n.arr.start = 1'b1;
              n.arr.kind = efcs_pkg::OP_PROG;
              n.arr.addr = s.base;
              n.ready = 1'b0;
            end
          end
          efcs_pkg::S_ECONF: begin
            n.seq = efcs_pkg::S_IDLE;
            if (cmd != efcs_pkg::CMD_GO) n.ilgl = 1'b1;
            else if (!s.wen[blk]) begin
              n.ilgl = 1'b1;
              n.wpe = 1'b1;
            end else begin
              n.arr.start = 1'b1;
              n.arr.kind = efcs_pkg::OP_ERASE;
              n.arr.addr = {blk, 13'h0000};
              n.ready = 1'b0;
            end
          end
          efcs_pkg::S_BCONF: begin
            n.seq = efcs_pkg::S_IDLE;
            if (cmd != efcs_pkg::CMD_GO) n.ilgl = 1'b1;
            else begin
              n.arr.start = 1'b1;
              n.arr.kind = efcs_pkg::OP_BLANK;
              n.arr.addr = s.check_size_bit ? {blk, 13'h0000} : {blk, s.bcOff, 3'b000};
              n.ready = 1'b0;
            end
          end
          default: n.seq = efcs_pkg::S_IDLE;
        endcase
      end
    end
    // verify failures land after the bus decode, so they win over a clear
    if (opDone && arrFail && s.arr.kind == efcs_pkg::OP_PROG) n.prg = 1'b1;
    if (opDone && arrFail && s.arr.kind == efcs_pkg::OP_ERASE) n.ers = 1'b1;
    // faults during an operation halt it with ready left low
    if (opAbort) begin
      n.flt = s.flt | arrFault;
      n.rdt = s.rdt | eccDetect;
      n.rcr = s.rcr | eccCorrect;
    end
    if (reset) begin
      n = '0;
      n.ready = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    s <= n;
  end

  assign rdata = s.rdata;
  assign arr = s.arr;
  assign irq = s.irq;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_fault_halt: assert property (opAbort |=> !s.ready [*2])
    else $error("ready rose after fault");
  a_done_clear: assert property (opDone |=> s.ready && !s.flt && !s.rdt && !s.rcr)
    else $error("done left fault flags");
  a_count_bad: assert property (cmdOk && !lock && s.ready && !opBusy
      && s.seq == efcs_pkg::S_COUNT && cmd != efcs_pkg::N_SMALL && cmd != efcs_pkg::N_LARGE
      |=> s.ilgl && !s.acc && !s.wpe && s.seq == efcs_pkg::S_IDLE)
    else $error("bad count not locked");
  a_prog_start: assert property (cmdOk && !lock && s.ready && !opBusy
      && s.seq == efcs_pkg::S_PCONF && cmd == efcs_pkg::CMD_GO && s.wen[s.base[16:13]]
      |=> s.arr.start && s.arr.kind == efcs_pkg::OP_PROG ##1 !s.ready && opBusy)
    else $error("program not started");
  a_entry_block: assert property (isEep && bus.wr && !romDisabled && !bus.fetch && !s.entD
      |=> s.ilgl && s.acc && !s.arr.start)
    else $error("write with entry clear accepted");
  a_wp_lock: assert property (cmdOk && !lock && s.ready && !opBusy
      && s.seq == efcs_pkg::S_ECONF && cmd == efcs_pkg::CMD_GO && !s.wen[blk]
      |=> s.ilgl && s.wpe && !s.arr.start)
    else $error("protected erase accepted");
  a_hw_protect: assert property (romDisabled && isEep && (bus.rd || bus.wr)
      |=> !s.arr.start && !s.arr.we && s.rdata == 16'h0000)
    else $error("access while rom disabled");
  a_lock_irq: assert property ($rose(lock) && s.lockIe |=> irq)
    else $error("no lock interrupt");
  a_busy_ready: assert property (opBusy |-> !s.ready)
    else $error("ready high while busy");
  a_locked_cmd: assert property (lock && cmdOk && cmd != efcs_pkg::CMD_CLEAR
      |=> s.ilgl && $stable(s.acc) && $stable(s.wpe) && $stable(s.prg))
    else $error("locked command changed flags");
  a_fetch_err: assert property (isEep && bus.rd && bus.fetch && !romDisabled
      |=> s.ilgl && s.ife)
    else $error("fetch not flagged");
  a_lock_read: assert property (bus.rd && bus.addr == efcs_pkg::A_ASTAT
      |=> rdata[4] == $past(lock))
    else $error("lock status mismatch");

  c_program: cover property (s.arr.start && s.arr.kind == efcs_pkg::OP_PROG);
  c_blank: cover property (opDone && s.arr.kind == efcs_pkg::OP_BLANK);
  c_unlock: cover property ($fell(lock));
  c_abort: cover property (opAbort);
endmodule

// >>> tb/efcs_array_model.sv
`timescale 1ns/1ps
// stand-in for the flash array: answers each launch with the outcome the bench picks
module efcs_array_model (
  input wire logic clock, // 40 MHz
  input wire efcs_pkg::efcs_arr_s arr, // array write and launch
  input wire logic blank, // report area erased
  input wire logic fail, // report verify failure
  input wire logic fault, // raise an internal fault mid-run
  output logic [15:0] arrRdata, // array read data
  output logic arrBlank, // erased flag
  output logic arrFail, // verify fail
  output logic arrFault, // internal fault
  output logic eccDetect, // read-detect error
  output logic eccCorrect // read-correct error
);
  logic [3:0] age = 4'hf;
  // cycles since the last launch, saturating
  always_ff @(posedge clock) begin
    if (arr.start) begin
      age <= 4'h0;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  // fault lands a few cycles into the run, while the operation is busy
  assign arrRdata = 16'hc3a5;
  assign arrBlank = blank;
  assign arrFail = fail;
  assign arrFault = fault && (age == 4'h3);
  // blank and fail held beside fault also raise the read errors
  assign eccDetect = fault && blank && (age == 4'h3);
  assign eccCorrect = fault && fail && (age == 4'h3);
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
// self-checking bench for the flash command sequencer
module tb;
  localparam logic [17:0] EA = 18'h20000; // eeprom block 0
  localparam logic [17:0] EB = 18'h24000; // eeprom block 2
  logic clock, reset, romDisabled, blank, fail, fault, irq;
  logic arrBlank, arrFail, arrFault, eccDetect, eccCorrect;
  logic [15:0] arrRdata, rdata, lastWd;
  logic [16:0] lastWe;
  efcs_pkg::efcs_bus_s bus;
  efcs_pkg::efcs_arr_s arr;
  int err_count = 0, tests_run = 0, weCnt = 0, startCnt = 0, irqCnt = 0;

  efcs_sequencer uut (.clock(clock), .reset(reset), .bus(bus), .romDisabled(romDisabled),
    .arrRdata(arrRdata), .arrBlank(arrBlank), .arrFail(arrFail), .arrFault(arrFault),
    .eccDetect(eccDetect), .eccCorrect(eccCorrect), .rdata(rdata), .arr(arr), .irq(irq));
  efcs_array_model mdl (.clock(clock), .arr(arr), .blank(blank), .fail(fail), .fault(fault),
    .arrRdata(arrRdata), .arrBlank(arrBlank), .arrFail(arrFail), .arrFault(arrFault),
    .eccDetect(eccDetect), .eccCorrect(eccCorrect));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // count array pulses and interrupts
  always @(posedge clock) begin
    if (arr.we === 1'b1) begin
      weCnt++;
      lastWe = arr.addr;
      lastWd = arr.wdata;
    end
    if (arr.start === 1'b1) startCnt++;
    if (irq === 1'b1) irqCnt++;
  end

  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s exp %h got %h", n, exp, got);
      err_count++;
    end
  endtask
  // one strobe cycle, then idle; rdata is valid on return
  task automatic put(input logic r, input logic w, input logic f, input logic wd,
                     input logic [17:0] a, input logic [15:0] d);
    bus <= '{rd: r, wr: w, fetch: f, word: wd, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
    #1;
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic wd);
    put(1'b0, 1'b1, 1'b0, wd, a, d);
    @(posedge clock);
  endtask
  task automatic rd(input logic [17:0] a, input logic [15:0] e, input string n);
    put(1'b1, 1'b0, 1'b0, 1'b1, a, 16'h0000);
    chk(n, rdata, e);
    @(posedge clock);
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(EA, {8'h00, c}, 1'b0);
  endtask
  // poll ready with a bounded count
  task automatic waitReady(input int lim);
    logic [15:0] s;
    s = 16'h0000;
    for (int k = 0; k < lim && s[7] !== 1'b1; k++) begin
      put(1'b1, 1'b0, 1'b0, 1'b1, 18'h00000, 16'h0000);
      s = rdata;
      @(posedge clock);
    end
  endtask
  task automatic prog(input logic [17:0] a, input logic [7:0] n);
    cmd(8'he8);
    cmd(n);
    for (int i = 0; i < n; i++) wr(a + 18'(2 * i), (i == n - 1) ? 16'hffff : 16'(i), 1'b1);
    cmd(8'hd0);
  endtask
  task automatic unlock();
    wr(18'h00008, 16'h0000, 1'b1);
    wr(18'h00010, 16'h0080, 1'b1);
    cmd(8'h50);
    rd(18'h00008, 16'h0000, "unlocked");
    rd(18'h00000, 16'h0080, "flags clear");
  endtask

  task automatic t_count();
    wr(18'h00010, 16'h0080, 1'b1);
    cmd(8'he8);
    cmd(8'h05);
    rd(18'h00000, 16'h00c0, "bad count");
    rd(18'h00008, 16'h0010, "lock only");
    cmd(8'h20);
    rd(18'h00008, 16'h0010, "locked cmd");
    chk("masked irq", 16'(irqCnt), 16'h0000);
    unlock();
  endtask
  task automatic t_entry();
    wr(18'h0000c, 16'h001f, 1'b1);
    wr(18'h00010, 16'h0000, 1'b1);
    cmd(8'he8);
    rd(18'h00000, 16'h00c0, "entry off");
    rd(18'h00008, 16'h0018, "access err");
    chk("irq", 16'(irqCnt != 0), 16'h0001);
    wr(18'h00010, 16'h0080, 1'b1);
    cmd(8'h50);
    rd(18'h00008, 16'h0018, "no early clear");
    unlock();
  endtask
  task automatic t_wp();
    startCnt = 0;
    prog(EB, 8'h04);
    rd(18'h00000, 16'h00c0, "wp illegal");
    rd(18'h00008, 16'h0011, "wp status");
    chk("wp start", 16'(startCnt), 16'h0000);
    unlock();
    cmd(8'h20);
    wr(EB, 16'h00d0, 1'b0);
    rd(18'h00008, 16'h0011, "erase wp");
    chk("erase start", 16'(startCnt), 16'h0000);
    unlock();
  endtask
  task automatic t_prog();
    wr(18'h00014, 16'h0004, 1'b1);
    weCnt = 0;
    startCnt = 0;
    prog(EB, 8'h04);
    rd(18'h00000, 16'h0000, "busy");
    waitReady(100);
    rd(18'h00000, 16'h0080, "done");
    chk("we 8", 16'(weCnt), 16'h0004);
    chk("last 8", 16'(lastWe), 16'h4006);
    chk("pad word", lastWd, 16'hffff);
    chk("prog base", 16'(arr.addr), 16'h4000);
    chk("start", 16'(startCnt), 16'h0001);
    prog(EB, 8'h40);
    waitReady(600);
    rd(18'h00000, 16'h0080, "done 128");
    chk("we 128", 16'(weCnt), 16'h0044);
    chk("last 128", 16'(lastWe), 16'h407e);
    cmd(8'h20);
    wr(EB + 18'h00100, 16'h00d0, 1'b0);
    rd(18'h00000, 16'h0000, "erasing");
    waitReady(2100);
    rd(18'h00000, 16'h0080, "erase done");
    chk("erase base", 16'(arr.addr), 16'h4000);
  endtask
  task automatic t_busy();
    startCnt = 0;
    prog(EB, 8'h04);
    cmd(8'he8);
    waitReady(100);
    rd(18'h00000, 16'h00c0, "op finished");
    chk("one start", 16'(startCnt), 16'h0001);
    unlock();
    fail <= 1'b1;
    prog(EB, 8'h04);
    waitReady(100);
    rd(18'h00000, 16'h0090, "prog err");
    rd(18'h00008, 16'h0010, "prog lock");
    fail <= 1'b0;
    unlock();
  endtask
  task automatic t_blank();
    wr(18'h0001c, 16'h0010, 1'b1);
    for (int i = 0; i < 2; i++) begin
      blank <= (i == 0);
      wr(18'h00020, (i == 0) ? 16'h8000 : 16'h0008, 1'b1);
      cmd(8'h71);
      wr(EB, 16'h00d0, 1'b0);
      waitReady(50);
      rd(18'h00024, 16'(i), "blank result");
      chk("blank area", 16'(arr.addr), (i == 0) ? 16'h4000 : 16'h4008);
      rd(18'h00000, 16'h0080, "blank end");
    end
  endtask
  task automatic t_read();
    wr(18'h00010, 16'h0000, 1'b1);
    put(1'b1, 1'b0, 1'b0, 1'b1, EB, 16'h0000);
    @(posedge clock);
    rd(18'h00008, 16'h0012, "rp err");
    unlock();
    wr(18'h00010, 16'h0000, 1'b1);
    wr(18'h00018, 16'h0004, 1'b1);
    rd(EB, 16'hc3a5, "array read");
    put(1'b1, 1'b0, 1'b1, 1'b1, EB, 16'h0000);
    @(posedge clock);
    rd(18'h00008, 16'h0014, "fetch err");
    unlock();
    cmd(8'hff);
    put(1'b1, 1'b0, 1'b0, 1'b1, EB, 16'h0000);
    @(posedge clock);
    rd(18'h00008, 16'h0018, "normal read");
    unlock();
  endtask
  task automatic t_rom();
    romDisabled <= 1'b1;
    cmd(8'he8);
    rd(18'h00000, 16'h0080, "rom off");
    rd(18'h00008, 16'h0000, "rom off st");
    romDisabled <= 1'b0;
  endtask
  task automatic t_fault();
    fault <= 1'b1;
    blank <= 1'b1;
    fail <= 1'b1;
    prog(EB, 8'h04);
    repeat (200) @(posedge clock);
    rd(18'h00000, 16'h0000, "halted");
    rd(18'h00004, 16'h0013, "fault flag");
    rd(18'h00008, 16'h0010, "fault lock");
    fault <= 1'b0;
    blank <= 1'b0;
    fail <= 1'b0;
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(18'h00000, 16'h0080, "after reset");
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    final_report();
  end
  // main sequence
  initial begin
    reset = 1'b1;
    romDisabled = 1'b0;
    blank = 1'b0;
    fail = 1'b0;
    fault = 1'b0;
    bus = '0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(18'h00000, 16'h0080, "reset ready");
    rd(18'h00008, 16'h0000, "reset lock");
    t_count();
    t_entry();
    t_wp();
    t_prog();
    t_busy();
    t_blank();
    t_read();
    t_rom();
    t_fault();
    final_report();
  end
endmodule
